// ---- logic/jbsp_top.sv ----
// boundary-scan test access port with register slave and device reset control
//
// What this block does
// - port works only with enable fuse programmed and interface disable bit clear.
// - software setting the interface disable bit turns the port off.
// - disable bit changes only on two equal writes within four cycles.
// - instruction register is four bits, sixteen codes.
// - all shift registers move least significant bit first.
// - code 0x0 selects boundary chain for external testing.
// - chain holds pin control, data, input and analog interface.
// - loading the external test code drives latched chain outputs at once.
// - external test captures pins, shifts chain, updates output pins.
// - code 0x1 selects 32-bit identification, default after power-up.
// - identification holds version, part number, maker; captured then shifted.
// - version field follows silicon revision upward from zero.
// - code 0x2 captures pins, shifts, loads latches without driving pins.
// - code 0xC selects one-bit reset register; controller not reset.
// - device held in reset while reset register is one, unlatched.
// - after release, reset lasts the fuse-selected time-out.
// - no high-impedance instruction; outside external test, device reset floats the pins instead.
// - code 0xF selects bypass stage, zero at capture, shifted after.
// - scan needs test clock slower than chip clock; tck is sampled on clk.
// - reset-cause bit 4 set by scan reset, cleared by power-on or zero write.
// - lock bits refuse debug fuse programming until chip erase.
// - sixteen-state controller stepped by mode line, starts in reset state.
// - five test clocks with mode high always reach reset state.
`timescale 1ns/1ps
module jbsp_top
    import jbsp_pkg::*;
#(
    parameter int NPINS = 8,
    parameter int ANA_W = 2,
    parameter int TIMEOUT_LONG_NS = 65000,
    parameter logic [3:0] SILICON_REV = 4'h0,
    // arbitrary neutral identity values
    parameter logic [15:0] PART_NUMBER = 16'h5A5A,
    parameter logic [10:0] MAKER_CODE = 11'h123
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register bus
    input wire jbsp_wb_req_t wb_req,
    output jbsp_wb_rsp_t wb_rsp,
    // test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // fuses and lock bits
    input wire logic jtag_enable_fuse,
    input wire logic clock_option_fuse,
    input wire logic lock_bit_one,
    input wire logic lock_bit_two,
    output logic debug_enable_fuse,
    // port pins and core side
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    output logic global_pullup_disable,
    input wire logic [NPINS-1:0] core_out,
    input wire logic [NPINS-1:0] core_oe,
    input wire logic [ANA_W-1:0] core_ana,
    output logic [ANA_W-1:0] ana_ctrl,
    // device reset
    output logic device_reset
);

    localparam int CHAIN = 2 * NPINS + ANA_W;
    localparam int TIMEOUT_LONG_CYC = (TIMEOUT_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef struct packed {
        logic [2:0] tck_sync;
        logic [2:0] tms_sync;
        logic [2:0] tdi_sync;
        logic [2:0][NPINS-1:0] pin_sync;
        logic tck_lvl;
        jbsp_tap_t tap;
        logic [3:0] ir_sr;
        logic [3:0] ir;
        logic bypass;
        logic [31:0] id_sr;
        logic rst_bit;
        logic [CHAIN-1:0] bsc_sr;
        logic [CHAIN-1:0] bsc_upd;
        logic tdo;
        logic tdo_oe;
        logic [NPINS-1:0] pin_out;
        logic [NPINS-1:0] pin_oe;
        logic [ANA_W-1:0] ana_ctrl;
        logic pullup_off;
        logic [15:0] rst_cnt;
        logic dev_rst;
        logic [7:0] mcu_ctrl;
        logic [7:0] cause;
        logic [2:0] dis_win_cnt;
        logic dis_win_val;
        logic dbg_fuse;
        logic erased;
        logic refused;
        jbsp_wb_rsp_t wb;
    } jbsp_reg_t;

    jbsp_reg_t s_r;
    jbsp_reg_t s_nxt;

    function automatic jbsp_tap_t tap_step(input jbsp_tap_t st, input logic m);
        unique case (st)
            TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: return m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: return m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: return m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: return m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: return m ? TAP_SEL_DR : TAP_IDLE;
            // select-IR with mode high heads for reset
            TAP_SEL_IR: return m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: return m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: return m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: return m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction : tap_step

    logic tap_on;
    logic tck_rise;
    logic tck_fall;
    logic tms_v;
    logic tdi_v;
    logic sel_chain;
    logic extest;
    logic bus_go;
    logic wr_commit;
    logic [7:0] wbyte;
    logic [CHAIN-1:0] capture;
    logic dr_lsb;

    always_comb
    begin
        s_nxt = s_r;
        // three-stage synchronisers; a tck change counts once stages 2 and 3 agree
        s_nxt.tck_sync = {s_r.tck_sync[1:0], tck};
        s_nxt.tms_sync = {s_r.tms_sync[1:0], tms};
        s_nxt.tdi_sync = {s_r.tdi_sync[1:0], tdi};
        s_nxt.pin_sync = {s_r.pin_sync[1:0], pin_in};
        tck_rise = 1'b0;
        tck_fall = 1'b0;
        if (s_r.tck_sync[1] == s_r.tck_sync[2] && s_r.tck_sync[2] != s_r.tck_lvl)
        begin
            s_nxt.tck_lvl = s_r.tck_sync[2];
            tck_rise = s_r.tck_sync[2];
            tck_fall = !s_r.tck_sync[2];
        end
        tms_v = s_r.tms_sync[2];
        tdi_v = s_r.tdi_sync[2];

        // fuse and disable bit gate the port
        tap_on = jtag_enable_fuse && !s_r.mcu_ctrl[MCU_DISABLE_BIT];
        // chain path for the two scan codes
        sel_chain = (s_r.ir == IR_EXTEST) || (s_r.ir == IR_SAMPLE_PRELOAD);
        extest = tap_on && (s_r.ir == IR_EXTEST);

        // control cells even, data cells odd, analog interface on top
        for (int i = 0; i < NPINS; i++)
        begin
            capture[2 * i] = s_r.pin_oe[i];
            capture[2 * i + 1] = s_r.pin_sync[2][i];
        end
        capture[CHAIN-1:2*NPINS] = core_ana;

        unique case (s_r.ir)
            IR_IDCODE: dr_lsb = s_r.id_sr[0];
            IR_DEVICE_RESET: dr_lsb = s_r.rst_bit;
            IR_EXTEST, IR_SAMPLE_PRELOAD: dr_lsb = s_r.bsc_sr[0];
            default: dr_lsb = s_r.bypass;
        endcase

        if (!tap_on)
        begin
            // disabled port sits in reset with data out released
            s_nxt.tap = TAP_RESET;
            s_nxt.ir = IR_IDCODE;
            s_nxt.tdo_oe = 1'b0;
            s_nxt.rst_bit = 1'b0;
        end
        else if (tck_rise)
        begin
            s_nxt.tap = tap_step(s_r.tap, tms_v);
            unique case (s_r.tap)
                TAP_RESET: s_nxt.ir = IR_IDCODE;
                TAP_CAP_IR: s_nxt.ir_sr = IR_CAPTURE;
                // lsb out first, tdi enters at msb
                TAP_SHIFT_IR: s_nxt.ir_sr = {tdi_v, s_r.ir_sr[3:1]};
                TAP_UPD_IR: s_nxt.ir = s_r.ir_sr;
                TAP_CAP_DR:
                begin
                    s_nxt.bypass = 1'b0;
                    s_nxt.id_sr = {SILICON_REV, PART_NUMBER, MAKER_CODE, 1'b1};
                    if (sel_chain)
                    begin
                        s_nxt.bsc_sr = capture;
                    end
                end
                TAP_SHIFT_DR:
                begin
                    // every data path shifts lsb first
                    unique case (s_r.ir)
                        IR_IDCODE: s_nxt.id_sr = {tdi_v, s_r.id_sr[31:1]};
                        // unlatched: the shifted bit acts at once
                        IR_DEVICE_RESET: s_nxt.rst_bit = tdi_v;
                        IR_EXTEST, IR_SAMPLE_PRELOAD: s_nxt.bsc_sr = {tdi_v, s_r.bsc_sr[CHAIN-1:1]};
                        default: s_nxt.bypass = tdi_v;
                    endcase
                end
                TAP_UPD_DR:
                begin
                    // acts on the rise leaving update, half a test clock late
                    // update loads latches only
                    if (sel_chain)
                    begin
                        s_nxt.bsc_upd = s_r.bsc_sr;
                    end
                end
                default:
                begin
                end
            endcase
        end
        else if (tck_fall)
        begin
            // data out moves on every falling edge, driven only in shift states
            s_nxt.tdo_oe = (s_r.tap == TAP_SHIFT_IR) || (s_r.tap == TAP_SHIFT_DR);
            s_nxt.tdo = (s_r.tap == TAP_SHIFT_IR) ? s_r.ir_sr[0] : dr_lsb;
        end

        // time-out starts after the reset bit falls
        // reload while high, so even a one-bit pulse gets the full time-out
        if (s_r.rst_bit)
        begin
            s_nxt.rst_cnt = clock_option_fuse ? 16'(TIMEOUT_LONG_CYC) : 16'(TIMEOUT_SHORT_CYC);
        end
        else if (s_r.rst_cnt != 16'h0000)
        begin
            s_nxt.rst_cnt = s_r.rst_cnt - 16'h0001;
        end
        s_nxt.dev_rst = s_r.rst_bit || (s_r.rst_cnt > 16'h0001);

        // limitation: scan values win over a pending device reset here
        // latched values reach pins as soon as the code is loaded
        if (extest)
        begin
            for (int i = 0; i < NPINS; i++)
            begin
                s_nxt.pin_oe[i] = s_r.bsc_upd[2 * i];
                s_nxt.pin_out[i] = s_r.bsc_upd[2 * i + 1];
            end
            s_nxt.ana_ctrl = s_r.bsc_upd[CHAIN-1:2*NPINS];
        end
        else
        begin
            s_nxt.pin_out = core_out;
            // pins float while the device is held in reset
            s_nxt.pin_oe = s_r.dev_rst ? '0 : core_oe;
            s_nxt.ana_ctrl = core_ana;
        end
        // pull-ups off while a scan code is active
        s_nxt.pullup_off = s_r.mcu_ctrl[MCU_PULLUP_OFF_BIT] || (tap_on && sel_chain);

        // classic single-cycle slave: ack one cycle after the request
        bus_go = wb_req.cyc && wb_req.stb;
        wr_commit = bus_go && wb_req.we && s_r.wb.ack && wb_req.sel[0];
        wbyte = wb_req.dat[7:0];
        s_nxt.wb.ack = bus_go && !s_r.wb.ack;
        s_nxt.wb.dat = 32'h0000_0000;
        if (bus_go && !s_r.wb.ack && !wb_req.we)
        begin
            unique case (wb_req.adr)
                OFS_MCU_CONTROL: s_nxt.wb.dat = {24'h000000, s_r.mcu_ctrl};
                OFS_RESET_CAUSE: s_nxt.wb.dat = {24'h000000, s_r.cause};
                OFS_FUSE_CONTROL: s_nxt.wb.dat = {29'h0000000, s_r.refused, s_r.erased, s_r.dbg_fuse};
                default: s_nxt.wb.dat = 32'h0000_0000;
            endcase
        end

        if (s_r.dis_win_cnt != 3'h0)
        begin
            s_nxt.dis_win_cnt = s_r.dis_win_cnt - 3'h1;
        end
        if (wr_commit && wb_req.adr == OFS_MCU_CONTROL)
        begin
            s_nxt.mcu_ctrl = (s_r.mcu_ctrl & ~MCU_RW_MASK) | (wbyte & MCU_RW_MASK);
            // second equal write inside the window commits
            if (s_r.dis_win_cnt != 3'h0 && wbyte[MCU_DISABLE_BIT] == s_r.dis_win_val)
            begin
                s_nxt.mcu_ctrl[MCU_DISABLE_BIT] = wbyte[MCU_DISABLE_BIT];
                s_nxt.dis_win_cnt = 3'h0;
            end
            else
            begin
                s_nxt.dis_win_val = wbyte[MCU_DISABLE_BIT];
                s_nxt.dis_win_cnt = DISABLE_WINDOW_CYC;
            end
        end

        if (wr_commit && wb_req.adr == OFS_RESET_CAUSE)
        begin
            s_nxt.cause = s_r.cause & wbyte & CAUSE_RW_MASK;
        end
        // scan reset sets the flag; set beats a clearing write
        if (s_r.rst_bit)
        begin
            s_nxt.cause[CAUSE_SCAN_RESET_BIT] = 1'b1;
        end

        if (wr_commit && wb_req.adr == OFS_FUSE_CONTROL)
        begin
            if (wbyte[FUSE_ERASE_BIT])
            begin
                s_nxt.erased = 1'b1;
                s_nxt.dbg_fuse = 1'b0;
                s_nxt.refused = 1'b0;
            end
            else if (wbyte[FUSE_PROG_BIT])
            begin
                // locked part needs an erase first
                if ((lock_bit_one || lock_bit_two) && !s_r.erased)
                    s_nxt.refused = 1'b1;
                else
                    s_nxt.dbg_fuse = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r <= '0;
            s_r.tap <= TAP_RESET;
            s_r.ir <= IR_IDCODE;
            s_r.mcu_ctrl <= MCU_RESET;
            s_r.cause <= CAUSE_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // everything runs on clk only; tck is just sampled
    assign wb_rsp = s_r.wb;
    assign tdo = s_r.tdo;
    assign tdo_oe = s_r.tdo_oe;
    assign debug_enable_fuse = s_r.dbg_fuse;
    assign pin_out = s_r.pin_out;
    assign pin_oe = s_r.pin_oe;
    assign global_pullup_disable = s_r.pullup_off;
    assign ana_ctrl = s_r.ana_ctrl;
    assign device_reset = s_r.dev_rst;

endmodule : jbsp_top

// ---- include/jbsp_pkg.sv ----
// package for the boundary-scan test port: constants, states and bus carriers
package jbsp_pkg;

    // clock rate
    localparam int CLK_PERIOD_PS = 8000;

    // register byte offsets
    localparam logic [7:0] OFS_MCU_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RESET_CAUSE = 8'h04;
    localparam logic [7:0] OFS_FUSE_CONTROL = 8'h08;

    // mcu_control fields
    localparam int MCU_DISABLE_BIT = 7;
    localparam int MCU_PULLUP_OFF_BIT = 4;
    localparam logic [7:0] MCU_RW_MASK = 8'h13;
    localparam logic [7:0] MCU_RESET = 8'h00;

    // reset_cause_status fields
    localparam int CAUSE_SCAN_RESET_BIT = 4;
    localparam logic [7:0] CAUSE_RW_MASK = 8'h1F;
    localparam logic [7:0] CAUSE_RESET = 8'h01;

    // fuse_control fields
    localparam int FUSE_PROG_BIT = 0;
    localparam int FUSE_ERASE_BIT = 1;
    localparam int FUSE_REFUSED_BIT = 2;

    // timed write window for the interface disable bit
    localparam logic [2:0] DISABLE_WINDOW_CYC = 3'h4;

    // short reset time-out, selected by clock option fuse low
    localparam int TIMEOUT_SHORT_NS = 1000;
    localparam int TIMEOUT_SHORT_CYC = (TIMEOUT_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // instruction codes
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_IDCODE = 4'h1;
    localparam logic [3:0] IR_SAMPLE_PRELOAD = 4'h2;
    localparam logic [3:0] IR_DEVICE_RESET = 4'hC;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jbsp_tap_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } jbsp_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } jbsp_wb_rsp_t;

endpackage : jbsp_pkg

// ---- testbench/jbsp_assertions.sv ----
// concurrent checks on the outer pins of the boundary-scan test port
`timescale 1ns/1ps
module jbsp_assertions
    import jbsp_pkg::*;
#(
    parameter int NPINS = 8,
    parameter int TIMEOUT_LONG_NS = 65000
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register bus
    input wire jbsp_wb_req_t wb_req,
    input wire jbsp_wb_rsp_t wb_rsp,
    // test port
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe,
    // fuses, pins and device reset
    input wire logic jtag_enable_fuse,
    input wire logic clock_option_fuse,
    input wire logic debug_enable_fuse,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic device_reset
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    localparam int LONG_CYC = TIMEOUT_LONG_NS * 1000 / CLK_PERIOD_PS;
    // counts how long the device has been held, reset bit time included
    logic [15:0] hi_cnt_r;
    logic [15:0] hi_cnt_nxt;
    always_comb hi_cnt_nxt = device_reset ? hi_cnt_r + 16'h1 : 16'h0;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            hi_cnt_r <= 16'h0;
        else
            hi_cnt_r <= hi_cnt_nxt;
    sequence bus_take_s;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    endsequence
    sequence ack_once_s;
        wb_rsp.ack ##1 !wb_rsp.ack;
    endsequence
    ack_next_a: assert property (bus_take_s |=> ack_once_s)
        else $error("bus answer not a single cycle after the request");
    ack_unasked_a: assert property ($rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb))
        else $error("bus answer without a request");
    rdat_idle_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
        else $error("read data not zero outside the answer");
    port_off_a: assert property (!jtag_enable_fuse [*4] |-> !tdo_oe)
        else $error("test data out driven with the enable fuse clear");
    tdo_low_a: assert property ($changed(tdo) |-> !tck)
        else $error("test data out moved while the test clock was high");
    oe_low_a: assert property ($changed(tdo_oe) |-> !tck)
        else $error("test data out enable moved while the test clock was high");
    reset_hold_a: assert property ($fell(device_reset) |->
        hi_cnt_r >= (clock_option_fuse ? LONG_CYC : TIMEOUT_SHORT_CYC))
        else $error("device reset released before its time-out");
    pins_float_a: assert property (device_reset [*2] |-> pin_oe == '0)
        else $error("pins driven while the device is held in reset");
    fuse_prog_a: assert property ($rose(debug_enable_fuse) |-> $past(wb_rsp.ack))
        else $error("debug fuse programmed without a register write");
endmodule : jbsp_assertions

bind jbsp_top jbsp_assertions #(.NPINS(NPINS), .TIMEOUT_LONG_NS(TIMEOUT_LONG_NS)) jbsp_assertions_inst (
    .clk(clk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
    .jtag_enable_fuse(jtag_enable_fuse), .clock_option_fuse(clock_option_fuse),
    .debug_enable_fuse(debug_enable_fuse), .pin_oe(pin_oe), .device_reset(device_reset));

// ---- testbench/jbsp_tester.sv ----
// model of the external test controller driving the port pins
`timescale 1ns/1ps
module jbsp_tester
(
    // clock
    input wire logic clk,
    // test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // sampled twice per test clock; the enable stands a whole half period
    logic oe_seen = 1'b0;
    // test clock rests low between frames
    initial tck = 1'b0;
    initial tms = 1'b1;
    initial tdi = 1'b0;
    task automatic clr();
        oe_seen = 1'b0;
    endtask : clr
    // one test clock of 160 ns, data out taken just before the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (10) @(posedge clk);
        o = tdo;
        oe_seen = oe_seen | tdo_oe;
        tck <= 1'b1;
        repeat (10) @(posedge clk);
        oe_seen = oe_seen | tdo_oe;
        tck <= 1'b0;
    endtask : step
    task automatic to_idle();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : to_idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        step(1'b1, 1'b0, o);
        if (ir)
            step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : scan
endmodule : jbsp_tester

// ---- testbench/jbsp_top_bench.sv ----
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module jbsp_top_bench
    import jbsp_pkg::*;
;
    localparam int NP = 8;
    localparam int AW = 2;
    localparam int CH = 2 * NP + AW;
    localparam logic [3:0] REV = 4'h3;
    // arbitrary neutral identity values
    localparam logic [15:0] PN = 16'h5A5A;
    localparam logic [10:0] MK = 11'h123;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    jbsp_wb_req_t wb_req = '0;
    jbsp_wb_rsp_t wb_rsp;
    logic tck, tms, tdi, tdo, tdo_oe, debug_enable_fuse, global_pullup_disable, device_reset;
    logic jtag_enable_fuse = 1'b1;
    logic clock_option_fuse = 1'b0;
    logic lock_bit_one = 1'b0;
    logic lock_bit_two = 1'b0;
    logic [NP-1:0] pin_in = 8'hA5;
    logic [NP-1:0] core_out = 8'h96;
    logic [NP-1:0] core_oe = 8'h0F;
    logic [NP-1:0] pin_out, pin_oe;
    logic [AW-1:0] core_ana = 2'h2;
    logic [AW-1:0] ana_ctrl;
    logic [31:0] sh;
    int error_cnt = 0;
    int tests_run = 0;

    jbsp_top #(.TIMEOUT_LONG_NS(200), .SILICON_REV(REV), .PART_NUMBER(PN), .MAKER_CODE(MK)) jbsp_top_inst (
        .clk, .reset_n, .wb_req, .wb_rsp, .tck, .tms, .tdi, .tdo, .tdo_oe, .jtag_enable_fuse,
        .clock_option_fuse, .lock_bit_one, .lock_bit_two, .debug_enable_fuse, .pin_in, .pin_out, .pin_oe,
        .global_pullup_disable, .core_out, .core_oe, .core_ana, .ana_ctrl, .device_reset);
    jbsp_tester jt (.clk, .tck, .tms, .tdi, .tdo, .tdo_oe);

    initial
    begin
        forever #4 clk = ~clk;
    end

    function automatic logic [CH-1:0] chain(input logic [NP-1:0] d, input logic [NP-1:0] c, input logic [AW-1:0] a);
        chain = {a, {2 * NP{1'b0}}};
        for (int i = 0; i < NP; i++)
            chain[2 * i +: 2] = {d[i], c[i]};
    endfunction : chain
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [7:0] wd, output logic [31:0] d);
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h0, wd}};
        @(posedge clk iff wb_rsp.ack);
        d = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb_io
    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        logic [31:0] d;
        wb_io(1'b1, adr, wd, d);
    endtask : wr
    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_io(1'b0, adr, 8'h00, d);
        check(d, exp);
    endtask : rdc
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rdc(OFS_MCU_CONTROL, 32'h00);
        rdc(OFS_RESET_CAUSE, 32'h01);
        rdc(8'h0C, 32'h00);
        jt.to_idle();
        jt.scan(1'b0, 32, 32'h0, sh);
        check(sh, {REV, PN, MK, 1'b1});
        jt.scan(1'b1, 4, {28'h0, IR_BYPASS}, sh);
        check(sh, 32'h1);
        jt.scan(1'b0, 4, 32'hB, sh);
        check(sh, 32'h6);
        $display("test idcode and bypass done");
        jt.scan(1'b1, 4, {28'h0, IR_SAMPLE_PRELOAD}, sh);
        jt.scan(1'b0, CH, 32'(chain(8'h5A, 8'hC3, 2'h1)), sh);
        check(sh, 32'(chain(pin_in, core_oe, core_ana)));
        check({global_pullup_disable, pin_out, pin_oe}, {1'b1, core_out, core_oe});
        jt.scan(1'b1, 4, {28'h0, IR_EXTEST}, sh);
        check({pin_out, pin_oe, ana_ctrl}, {8'h5A, 8'hC3, 2'h1});
        pin_in <= 8'h3C;
        jt.scan(1'b0, CH, 32'(chain(8'hF0, 8'h0F, 2'h2)), sh);
        check(sh, 32'(chain(8'h3C, 8'hC3, core_ana)));
        check({pin_out, pin_oe, ana_ctrl}, {8'hF0, 8'h0F, 2'h2});
        $display("test boundary chain done");
        jt.scan(1'b1, 4, {28'h0, IR_DEVICE_RESET}, sh);
        jt.scan(1'b0, 1, 32'h1, sh);
        check({device_reset, pin_oe}, {1'b1, 8'h00});
        rdc(OFS_RESET_CAUSE, 32'h11);
        jt.scan(1'b0, 1, 32'h0, sh);
        check(sh, 32'h1);
        check(device_reset, 1'b1);
        repeat (300) @(posedge clk);
        check(device_reset, 1'b0);
        wr(OFS_RESET_CAUSE, 8'h0F);
        rdc(OFS_RESET_CAUSE, 32'h01);
        $display("test device reset done");
        wr(OFS_MCU_CONTROL, 8'h93);
        rdc(OFS_MCU_CONTROL, 32'h13);
        repeat (8) @(posedge clk);
        wr(OFS_MCU_CONTROL, 8'h80);
        wr(OFS_MCU_CONTROL, 8'h80);
        rdc(OFS_MCU_CONTROL, 32'h80);
        jt.clr();
        jt.scan(1'b0, 32, 32'h0, sh);
        check(jt.oe_seen, 1'b0);
        wr(OFS_MCU_CONTROL, 8'h00);
        wr(OFS_MCU_CONTROL, 8'h00);
        rdc(OFS_MCU_CONTROL, 32'h00);
        jt.to_idle();
        jt.clr();
        jt.scan(1'b0, 32, 32'h0, sh);
        check(sh, {REV, PN, MK, 1'b1});
        check(jt.oe_seen, 1'b1);
        jtag_enable_fuse <= 1'b0;
        jt.clr();
        jt.scan(1'b1, 4, 32'hF, sh);
        check(jt.oe_seen, 1'b0);
        jtag_enable_fuse <= 1'b1;
        $display("test port enable done");
        {lock_bit_one, lock_bit_two} <= 2'b11;
        wr(OFS_FUSE_CONTROL, 8'h01);
        rdc(OFS_FUSE_CONTROL, 32'h04);
        wr(OFS_FUSE_CONTROL, 8'h02);
        wr(OFS_FUSE_CONTROL, 8'h01);
        rdc(OFS_FUSE_CONTROL, 32'h03);
        check(debug_enable_fuse, 1'b1);
        $display("test fuse guard done");
        tally_and_finish();
    end
endmodule : jbsp_top_bench
